// >>> src/bet_top.sv
// Purpose: Bit error rate tester on the demodulated bit stream
// Assumes: Bit clock and data pins are asynchronous to clk, bit rate well below clk/4
// Notes:   Registers on a plain strobe port, read data one cycle after the strobe
`timescale 1ns/1ps
module bet_top #(
   parameter int TICKS_PER_SEC = bet_pkg::SEC_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  bet_pkg::bet_addr_t addr,
   input  bet_pkg::bet_word_t wr_data,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output bet_pkg::bet_word_t rd_data,
   input  wire logic        rx_clk_pin,
   input  wire logic        rx_data_pin,
   output logic             meas_running,
   output logic             pattern_locked
);
   import bet_pkg::*;

   typedef enum logic {ST_STOPPED, ST_RUNNING} bet_state_t;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   bet_state_t        st_q, st_d;
   logic              en_q, en_d;
   logic              lim_q, lim_d;
   logic              rep_q, rep_d;
   logic              clr_q, clr_d;
   bet_pat_t          sel_q, sel_d;
   bet_word_t         upat_q, upat_d;
   logic [ULEN_W-1:0] ulen_q, ulen_d;
   bet_word_t         tlim_q, tlim_d;
   bet_word_t         blim_q, blim_d;
   bet_word_t         elim_q, elim_d;
   bet_word_t         bits_q, bits_d;
   bet_word_t         errs_q, errs_d;
   bet_word_t         secs_q, secs_d;
   bet_word_t         tick_q, tick_d;
   logic              done_q, done_d;
   bet_word_t         rd_data_d;
   logic              clk_s1, clk_s2, clk_s3;
   logic              dat_s1, dat_s2;
   logic              step;
   logic              mismatch;
   logic              lost;
   logic              measurement_restart;
   logic              limit_hit;
   logic              loss_clr;

   bet_ref_if ref_if ();

   function automatic logic hit(input bet_word_t lim, input bet_word_t cnt);
      return (lim != '0) && (cnt >= lim);
   endfunction : hit

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         dat_s1 <= 1'b0;
         dat_s2 <= 1'b0;
      end
      else
      begin
         clk_s1 <= rx_clk_pin;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         dat_s1 <= rx_data_pin;
         dat_s2 <= dat_s1;
      end
   end

   // Rising bit-clock edge; data seen through the same two-flop delay
   assign step     = clk_s2 & ~clk_s3;
   assign mismatch = dat_s2 ^ ref_if.ref_bit;

   // ----------------------------------------
   // Reference generator and sync
   // ----------------------------------------
   assign ref_if.sel      = sel_q;
   assign ref_if.user_pat = upat_q;
   assign ref_if.user_len = ulen_q;
   assign ref_if.step     = step;
   assign ref_if.rx_bit   = dat_s2;
   assign ref_if.locked   = pattern_locked;

   bet_refgen u_refgen (
      .clk   (clk),
      .reset (reset),
      .rif   (ref_if.gen)
   );

   bet_sync u_sync (
      .clk      (clk),
      .reset    (reset),
      .step     (step),
      .mismatch (mismatch),
      .resync   (measurement_restart),
      .locked   (pattern_locked),
      .lost     (lost)
   );

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   assign measurement_restart = wr_stb && addr == OFS_CMD && wr_data[CMD_RESTART];

   always_comb
   begin
      en_d   = en_q;
      lim_d  = lim_q;
      rep_d  = rep_q;
      clr_d  = clr_q;
      sel_d  = sel_q;
      upat_d = upat_q;
      ulen_d = ulen_q;
      tlim_d = tlim_q;
      blim_d = blim_q;
      elim_d = elim_q;
      if (wr_stb)
      begin
         unique case (addr)
            OFS_CTRL:
            begin
               en_d  = wr_data[CTRL_EN];
               lim_d = wr_data[CTRL_LIMITED];
               rep_d = wr_data[CTRL_REPEAT];
               clr_d = wr_data[CTRL_CLR_LOSS];
               // Undefined pattern codes leave the selection unchanged
               if (wr_data[CTRL_SEL_LSB +: SEL_W] <= PAT_USER)
                  sel_d = bet_pat_t'(wr_data[CTRL_SEL_LSB +: SEL_W]);
            end
            OFS_UPAT: upat_d = wr_data;
            OFS_ULEN: ulen_d = wr_data[ULEN_W-1:0];
            OFS_TLIM: tlim_d = wr_data;
            OFS_BLIM: blim_d = wr_data;
            OFS_ELIM: elim_d = wr_data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         en_q   <= 1'b0;
         lim_q  <= 1'b0;
         rep_q  <= RST_REPEAT;
         clr_q  <= 1'b0;
         sel_q  <= RST_SEL;
         upat_q <= RST_UPAT;
         ulen_q <= RST_ULEN;
         tlim_q <= '0;
         blim_q <= '0;
         elim_q <= '0;
      end
      else
      begin
         en_q   <= en_d;
         lim_q  <= lim_d;
         rep_q  <= rep_d;
         clr_q  <= clr_d;
         sel_q  <= sel_d;
         upat_q <= upat_d;
         ulen_q <= ulen_d;
         tlim_q <= tlim_d;
         blim_q <= blim_d;
         elim_q <= elim_d;
      end
   end

   // ----------------------------------------
   // Measurement control and counters
   // ----------------------------------------
   assign limit_hit = st_q == ST_RUNNING && en_q && lim_q
      && (hit(tlim_q, secs_q) || hit(blim_q, bits_q) || hit(elim_q, errs_q));
   assign loss_clr = clr_q && lost;

   always_comb
   begin
      st_d   = st_q;
      bits_d = bits_q;
      errs_d = errs_q;
      secs_d = secs_q;
      tick_d = tick_q;
      unique case (st_q)
         ST_STOPPED:
         begin
            if (en_q && measurement_restart)
            begin
               st_d   = ST_RUNNING;
               bits_d = '0;
               errs_d = '0;
               secs_d = '0;
               tick_d = '0;
            end
         end
         ST_RUNNING:
         begin
            if (!en_q)
               st_d = ST_STOPPED;
            else if (measurement_restart || (limit_hit && rep_q))
            begin
               bits_d = '0;
               errs_d = '0;
               secs_d = '0;
               tick_d = '0;
            end
            else if (limit_hit)
               st_d = ST_STOPPED;
            else
            begin
               // Bits count only while the reference is aligned
               if (step && pattern_locked)
               begin
                  bits_d = bits_q + 32'h0000_0001;
                  errs_d = errs_q + 32'(mismatch);
               end
               if (tick_q == 32'(TICKS_PER_SEC - 1))
               begin
                  tick_d = '0;
                  secs_d = secs_q + 32'h0000_0001;
               end
               else
                  tick_d = tick_q + 32'h0000_0001;
            end
         end
      endcase
      // Clearing is not counting, so it acts even when stopped
      if (loss_clr)
      begin
         bits_d = '0;
         errs_d = '0;
      end
      // A completion in the same cycle as a restart still sets the flag
      if (limit_hit)
         done_d = 1'b1;
      else if (measurement_restart && en_q)
         done_d = 1'b0;
      else
         done_d = done_q;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         st_q         <= ST_STOPPED;
         bits_q       <= '0;
         errs_q       <= '0;
         secs_q       <= '0;
         tick_q       <= '0;
         done_q       <= 1'b0;
         meas_running <= 1'b0;
      end
      else
      begin
         st_q         <= st_d;
         bits_q       <= bits_d;
         errs_q       <= errs_d;
         secs_q       <= secs_d;
         tick_q       <= tick_d;
         done_q       <= done_d;
         meas_running <= st_d == ST_RUNNING;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_comb
   begin
      rd_data_d = '0;
      if (rd_stb)
      begin
         unique case (addr)
            OFS_CTRL:
            begin
               rd_data_d[CTRL_EN]                   = en_q;
               rd_data_d[CTRL_LIMITED]              = lim_q;
               rd_data_d[CTRL_REPEAT]               = rep_q;
               rd_data_d[CTRL_CLR_LOSS]             = clr_q;
               rd_data_d[CTRL_SEL_LSB +: SEL_W]     = sel_q;
            end
            OFS_UPAT: rd_data_d = upat_q;
            OFS_ULEN: rd_data_d[ULEN_W-1:0] = ulen_q;
            OFS_TLIM: rd_data_d = tlim_q;
            OFS_BLIM: rd_data_d = blim_q;
            OFS_ELIM: rd_data_d = elim_q;
            OFS_STAT:
            begin
               rd_data_d[STAT_RUN]  = st_q == ST_RUNNING;
               rd_data_d[STAT_LOCK] = pattern_locked;
               rd_data_d[STAT_DONE] = done_q;
            end
            OFS_BITS: rd_data_d = bits_q;
            OFS_ERRS: rd_data_d = errs_q;
            OFS_SECS: rd_data_d = secs_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         rd_data <= '0;
      else
         rd_data <= rd_data_d;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   cont_runs_a: assert property (st_q == ST_RUNNING && en_q && !lim_q
      && !measurement_restart |=> st_q == ST_RUNNING) else $error("continuous run ended");
   any_limit_a: assert property (limit_hit |=> done_q)
      else $error("completion not flagged");
   time_limit_a: assert property (st_q == ST_RUNNING && en_q && lim_q && !rep_q
      && tlim_q != '0 && secs_q >= tlim_q && !measurement_restart
      |=> st_q == ST_STOPPED) else $error("time limit missed");
   bit_limit_a: assert property (st_q == ST_RUNNING && en_q && lim_q
      && blim_q != '0 && bits_q >= blim_q && !measurement_restart
      |=> st_q == ST_STOPPED || bits_q == '0) else $error("bit limit missed");
   err_limit_a: assert property (st_q == ST_RUNNING && en_q && lim_q
      && elim_q != '0 && errs_q >= elim_q && !measurement_restart
      |=> st_q == ST_STOPPED || errs_q == '0) else $error("error limit missed");
   single_stop_a: assert property (limit_hit && !rep_q && !measurement_restart
      |=> st_q == ST_STOPPED ##1 (st_q == ST_STOPPED || $past(measurement_restart)))
      else $error("single run restarted");
   repeat_run_a: assert property (limit_hit && rep_q
      |=> st_q == ST_RUNNING && bits_q == '0 && errs_q == '0 && secs_q == '0)
      else $error("repeat run not fresh");
   loss_clear_a: assert property (loss_clr |=> bits_q == '0 && errs_q == '0)
      else $error("counts kept after sync loss");
   count_bit_a: assert property (st_q == ST_RUNNING && en_q && step && pattern_locked
      && !limit_hit && !measurement_restart && !loss_clr
      |=> bits_q == $past(bits_q) + 32'h0000_0001
          && errs_q == $past(errs_q) + 32'($past(mismatch))) else $error("bit not counted");
   off_hold_a: assert property (!en_q && !loss_clr
      |=> $stable(bits_q) && $stable(errs_q)) else $error("counting while disabled");
   restart_zero_a: assert property (measurement_restart && en_q
      |=> meas_running && bits_q == '0 && errs_q == '0) else $error("restart not clean");
   zero_limit_a: assert property (st_q == ST_RUNNING && en_q && lim_q
      && tlim_q == '0 && blim_q == '0 && elim_q == '0 |=> st_q == ST_RUNNING)
      else $error("zero limit ended run");

   repeat_c: cover property (limit_hit && rep_q);
   single_c: cover property (limit_hit && !rep_q ##1 st_q == ST_STOPPED);
   loss_c:   cover property (loss_clr && st_q == ST_RUNNING);
endmodule : bet_top

// >>> src/bet_pkg.sv
// Purpose: Shared constants and types of the bit error tester
// Assumes: 200 MHz system clock, byte addresses on the register port
// Notes:   Pattern codes follow the enum order below
package bet_pkg;
   // ----------------------------------------
   // Bus shape
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   typedef logic [ADDR_W-1:0] bet_addr_t;
   typedef logic [DATA_W-1:0] bet_word_t;
   typedef enum logic [3:0] {PAT_PN6, PAT_PN9, PAT_PN11, PAT_PN15,
                             PAT_PN17, PAT_PN20, PAT_PN23, PAT_PN31,
                             PAT_USER} bet_pat_t;
   // ----------------------------------------
   // Register offsets and fields
   // ----------------------------------------
   localparam bet_addr_t OFS_CTRL = 8'h00;
   localparam bet_addr_t OFS_CMD  = 8'h04;
   localparam bet_addr_t OFS_UPAT = 8'h08;
   localparam bet_addr_t OFS_ULEN = 8'h0C;
   localparam bet_addr_t OFS_TLIM = 8'h10;
   localparam bet_addr_t OFS_BLIM = 8'h14;
   localparam bet_addr_t OFS_ELIM = 8'h18;
   localparam bet_addr_t OFS_STAT = 8'h1C;
   localparam bet_addr_t OFS_BITS = 8'h20;
   localparam bet_addr_t OFS_ERRS = 8'h24;
   localparam bet_addr_t OFS_SECS = 8'h28;
   localparam int CTRL_EN = 0, CTRL_LIMITED = 1, CTRL_REPEAT = 2, CTRL_CLR_LOSS = 3;
   localparam int CTRL_SEL_LSB = 4, SEL_W = 4, CMD_RESTART = 0;
   localparam int STAT_RUN = 0, STAT_LOCK = 1, STAT_DONE = 2;
   localparam int ULEN_W = 6;
   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam bet_pat_t RST_SEL = PAT_PN15;
   localparam logic RST_REPEAT = 1'b1;
   localparam logic [ULEN_W-1:0] ULEN_MIN = 6'h02, ULEN_MAX = 6'h20, RST_ULEN = 6'h04;
   localparam bet_word_t RST_UPAT = 32'h0000_000B;
   // ----------------------------------------
   // Sequences, sync and timing
   // ----------------------------------------
   localparam int PN_LEN [8] = '{6, 9, 11, 15, 17, 20, 23, 31};
   localparam int PN_TAP [8] = '{5, 5, 9, 14, 14, 3, 18, 28};
   localparam logic [5:0] SYNC_RUN = 6'h20;
   localparam logic [6:0] LOSS_WIN = 7'h40, LOSS_ERR = 7'h10;
   localparam int SECOND_S = 1;
   localparam int CLK_HZ = 200_000_000;
   localparam int SEC_CYCLES = SECOND_S * CLK_HZ;
endpackage : bet_pkg

// >>> src/bet_ref_if.sv
// Purpose: Links the tester core to its reference generator
// Assumes: One clock domain
// Notes:   ctl side drives, gen side returns the reference bit
`timescale 1ns/1ps
interface bet_ref_if;
   import bet_pkg::*;
   bet_pat_t            sel;
   bet_word_t           user_pat;
   logic [ULEN_W-1:0]   user_len;
   logic                step;
   logic                rx_bit;
   logic                locked;
   logic                ref_bit;
   modport gen (input sel, user_pat, user_len, step, rx_bit, locked, output ref_bit);
   modport ctl (output sel, user_pat, user_len, step, rx_bit, locked, input ref_bit);
endinterface : bet_ref_if

// >>> src/bet_refgen.sv
// Purpose: Local reference sequence, aligned to the received stream
// Assumes: step is one cycle per received bit
// Notes:   PN modes self-seed from received bits until locked; user mode holds its pointer on a mismatch only until locked
`timescale 1ns/1ps
module bet_refgen (
   input wire logic clk,
   input wire logic reset,
   bet_ref_if.gen   rif
);
   import bet_pkg::*;
   logic [30:0] hist_q, hist_d;
   logic [4:0]  pos_q, pos_d;
   logic [4:0]  last;

   function automatic logic [4:0] last_pos(input logic [ULEN_W-1:0] len);
      if (len < ULEN_MIN)
         return 5'(ULEN_MIN - 6'h01);
      else if (len > ULEN_MAX)
         return 5'(ULEN_MAX - 6'h01);
      else
         return 5'(len - 6'h01);
   endfunction : last_pos

   // ----------------------------------------
   // Reference bit and next state
   // ----------------------------------------
   always_comb
   begin
      last = last_pos(rif.user_len);
      if (rif.sel == PAT_USER)
         rif.ref_bit = rif.user_pat[pos_q];
      else
         rif.ref_bit = hist_q[PN_LEN[int'(rif.sel)]-1] ^ hist_q[PN_TAP[int'(rif.sel)]-1];
      hist_d = hist_q;
      pos_d  = pos_q;
      if (rif.step && rif.sel != PAT_USER)
         // Locked: predicted bit fed back so errors do not propagate
         hist_d = {hist_q[29:0], rif.locked ? rif.ref_bit : rif.rx_bit};
      else if (rif.step && (rif.locked || rif.rx_bit == rif.ref_bit))
         pos_d = (pos_q == 5'h00) ? last : pos_q - 5'h01;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         hist_q <= '0;
         pos_q  <= '0;
      end
      else
      begin
         hist_q <= hist_d;
         pos_q  <= pos_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   pn_feed_a: assert property (rif.step && rif.sel != PAT_USER && rif.locked
      |=> hist_q[0] == $past(rif.ref_bit)) else $error("pn feedback wrong");
   user_wrap_a: assert property (rif.step && rif.sel == PAT_USER && rif.locked
      && pos_q == 5'h00 |=> pos_q == $past(last)) else $error("user wrap wrong");
   user_only_a: assert property (rif.sel != PAT_USER |=> $stable(pos_q))
      else $error("user pointer moved in pn mode");
endmodule : bet_refgen

// >>> src/bet_sync.sv
// Purpose: Pattern sync detector
// Assumes: step marks each compared bit
// Notes:   Lock after a clean run, loss after too many errors per window
`timescale 1ns/1ps
module bet_sync (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic step,
   input  wire logic mismatch,
   input  wire logic resync,
   output logic      locked,
   output logic      lost
);
   import bet_pkg::*;
   logic [5:0] run_q, run_d;
   logic [6:0] win_q, win_d, werr_q, werr_d;
   logic       lock_d, lost_d;

   always_comb
   begin
      run_d  = run_q;
      win_d  = win_q;
      werr_d = werr_q;
      lock_d = locked;
      lost_d = 1'b0;
      if (resync)
      begin
         run_d  = '0;
         lock_d = 1'b0;
      end
      else if (step && !locked)
      begin
         run_d = mismatch ? 6'h00 : run_q + 6'h01;
         if (!mismatch && run_q == SYNC_RUN - 6'h01)
         begin
            lock_d = 1'b1;
            win_d  = '0;
            werr_d = '0;
         end
      end
      else if (step)
      begin
         win_d  = win_q + 7'h01;
         werr_d = werr_q + 7'(mismatch);
         if (werr_d >= LOSS_ERR)
         begin
            lock_d = 1'b0;
            lost_d = 1'b1;
            run_d  = '0;
         end
         else if (win_q == LOSS_WIN - 7'h01)
         begin
            win_d  = '0;
            werr_d = '0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         run_q  <= '0;
         win_q  <= '0;
         werr_q <= '0;
         locked <= 1'b0;
         lost   <= 1'b0;
      end
      else
      begin
         run_q  <= run_d;
         win_q  <= win_d;
         werr_q <= werr_d;
         locked <= lock_d;
         lost   <= lost_d;
      end
   end

   sync_gain_a: assert property (@(posedge clk) disable iff (reset)
      !locked && step && !mismatch && !resync && run_q == SYNC_RUN - 6'h01 |=> locked)
      else $error("lock not declared after clean run");
endmodule : bet_sync

// >>> sim/bet_src.sv
// Purpose: Demodulator stand-in sending a repeating user pattern or a six-stage PN sequence
// Assumes: Eight clk per bit, bit clock runs through the whole test
// Notes:   Data moves one clk before the bit clock rises, held seven after
`timescale 1ns/1ps
module bet_src (
   input  wire logic        clk,
   input  wire logic [31:0] pat,
   input  wire logic [5:0]  len,
   input  wire logic        flip,
   input  wire logic        pn,
   output logic             bclk,
   output logic             bdat
);
   logic [2:0] ph_q = 3'h0;
   logic [5:0] idx_q = 6'h0;
   logic [5:0] pn_q = 6'h01;
   always_ff @(posedge clk)
   begin
      ph_q <= ph_q + 3'h1;
      bclk <= ph_q[2];
      if (ph_q == 3'h3)
      begin
         // Msb first; flip held a bit period corrupts exactly one bit
         if (pn)
            bdat <= pn_q[5] ^ pn_q[4] ^ flip;
         else
            bdat <= pat[len - 6'h1 - idx_q] ^ flip;
         idx_q <= (idx_q + 6'h1 == len) ? 6'h0 : idx_q + 6'h1;
         // Newest bit in the lsb, taps at orders six and five
         pn_q <= {pn_q[4:0], pn_q[5] ^ pn_q[4]};
      end
   end
endmodule : bet_src

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the bit error tester
// Assumes: One second shortened to 20 clk
// Notes:   Bus tasks add one idle cycle after each strobe
`timescale 1ns/1ps
module testbench;
   import bet_pkg::*;
   logic      clk, reset, wr_stb, rd_stb, flip, pn, bclk, bdat, meas_running, pattern_locked;
   bet_addr_t addr;
   bet_word_t wr_data, rd_data, v, w;
   int        errors = 0, checks = 0;
   bet_top #(.TICKS_PER_SEC(20)) u_dut (.clk(clk), .reset(reset), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .rx_clk_pin(bclk), .rx_data_pin(bdat), .meas_running(meas_running),
      .pattern_locked(pattern_locked));
   bet_src u_src (.clk(clk), .pat(32'h0000_0016), .len(6'h05), .flip(flip), .bclk(bclk),
      .pn(pn), .bdat(bdat));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic chk(input string n, input bet_word_t s, input bet_word_t e);
      checks++;
      if (s !== e)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input bet_addr_t a, input bet_word_t d);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input bet_addr_t a, output bet_word_t d);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
      @(posedge clk);
   endtask : rd
   task automatic rc(input string n, input bet_addr_t a, input bet_word_t e);
      rd(a, v);
      chk(n, v, e);
   endtask : rc
   task automatic wait_stop;
      v = 32'h1;
      repeat (1500) if (v[STAT_RUN]) rd(OFS_STAT, v);
   endtask : wait_stop
   task automatic go(input bet_word_t c);
      wr(OFS_CTRL, c);
      wr(OFS_CMD, 32'h1);
      repeat (800) if (!pattern_locked) @(posedge clk);
   endtask : go
   task automatic results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      #200000;
      errors++;
      results();
   end
   initial
   begin
      {reset, wr_stb, rd_stb, flip, pn, addr, wr_data} <= {5'h10, 8'h00, 32'h0};
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rc("ctrl", OFS_CTRL, 32'h0000_0034);
      rc("ulen", OFS_ULEN, 32'h0000_0004);
      rc("upat", OFS_UPAT, 32'h0000_000B);
      rc("hole", 8'h30, 32'h0);
      $display("reset test done");
      wr(OFS_UPAT, 32'h0000_0016);
      wr(OFS_ULEN, 32'h0000_0005);
      wr(OFS_BLIM, 32'h0000_0064);
      go(32'h0000_0083);
      chk("lock", {31'h0, pattern_locked}, 32'h1);
      wait_stop();
      repeat (80) @(posedge clk);
      rc("bits", OFS_BITS, 32'h0000_0064);
      rc("errs", OFS_ERRS, 32'h0);
      rc("stat", OFS_STAT, 32'h0000_0006);
      $display("bit limit test done");
      wr(OFS_BLIM, 32'h0);
      wr(OFS_ELIM, 32'h0000_0003);
      go(32'h0000_0083);
      rc("bits0", OFS_BITS, 32'h0);
      repeat (3)
      begin
         flip <= 1'b1;
         repeat (8) @(posedge clk);
         flip <= 1'b0;
         repeat (160) @(posedge clk);
      end
      wait_stop();
      rc("errs", OFS_ERRS, 32'h0000_0003);
      $display("error limit test done");
      wr(OFS_ELIM, 32'h0);
      wr(OFS_TLIM, 32'h0000_000A);
      go(32'h0000_0087);
      repeat (600) @(posedge clk);
      chk("repeat", {31'h0, meas_running}, 32'h1);
      rc("rdone", OFS_STAT, 32'h0000_0007);
      go(32'h0000_0083);
      wait_stop();
      rc("secs", OFS_SECS, 32'h0000_000A);
      $display("time limit test done");
      go(32'h0000_0081);
      repeat (400) @(posedge clk);
      chk("cont", {31'h0, meas_running}, 32'h1);
      wr(OFS_CTRL, 32'h0000_0080);
      rd(OFS_BITS, w);
      repeat (200) @(posedge clk);
      rc("hold", OFS_BITS, w);
      $display("enable test done");
      go(32'h0000_0089);
      repeat (300) @(posedge clk);
      flip <= 1'b1;
      repeat (800) if (pattern_locked) @(posedge clk);
      flip <= 1'b0;
      rc("clr", OFS_BITS, 32'h0);
      $display("sync loss test done");
      pn <= 1'b1;
      wr(OFS_TLIM, 32'h0);
      wr(OFS_BLIM, 32'h0000_0040);
      go(32'h0000_0003);
      chk("pnlock", {31'h0, pattern_locked}, 32'h1);
      wait_stop();
      rc("pnerrs", OFS_ERRS, 32'h0);
      rc("pnbits", OFS_BITS, 32'h0000_0040);
      $display("pn test done");
      results();
   end
endmodule : testbench
